// file: logic/rstack_regs.svh
// register offsets, field positions and reset values of the return stack
`ifndef RSTACK_REGS_SVH
`define RSTACK_REGS_SVH

`define RSTACK_POS_OFFSET      12'h000
`define RSTACK_STATUS_OFFSET   12'h004
`define RSTACK_CLEAR_OFFSET    12'h008
`define RSTACK_ENABLE_OFFSET   12'h00C
`define RSTACK_CONFIG_OFFSET   12'h010

`define RSTACK_POS_MSB         4
`define RSTACK_POS_LSB         0
`define RSTACK_POS_RESET       5'h00

`define RSTACK_FULL_BIT        0
`define RSTACK_EMPTY_BIT       1
`define RSTACK_EVENT_RESET     2'h0
`define RSTACK_ENABLE_RESET    2'h0

`define RSTACK_CFG_FAULT_BIT   0
`define RSTACK_CFG_RESET       1'h1

`define RSTACK_DEPTH           31
`define RSTACK_PC_WIDTH        21

`endif

// file: logic/rstack_pkg.sv
// types shared by the return stack block and its bench
package rstack_pkg;

   // one request from the instruction sequencer per cycle
   typedef struct packed {
      logic push;      // call or interrupt vector
      logic pop;       // any return
      logic vector;    // push is an interrupt entry
      logic fast;      // fast option on call or return
   } seq_op_t;

   // the three registers that the shadow copy mirrors
   typedef struct packed {
      logic [7:0] status;
      logic [7:0] working;
      logic [7:0] bank;
   } core_regs_t;

   typedef struct packed {
      logic empty;
      logic full;
   } stack_events_t;

endpackage : rstack_pkg

// file: logic/return_stack_fault_and_shadow.sv
// return address stack with fault flags, fault reset and fast shadow copy
`timescale 1ns/1ps
`default_nettype none
`include "rstack_regs.svh"

// Summary of operation
// - position is a writable 5-bit field, upper 27 bits read zero.
// - with fault reset enabled, full or underflow sets its flag then resets.
// - with fault reset disabled, full or underflow only sets its flag.
// - full and empty flags stay set until software or power-on clears them.
// - one shadow entry each for status, working and bank; not accessible.
// - every interrupt vector loads the shadow entries with current values.
// - fast interrupt return copies shadow entries back into the registers.
// - a nested high priority entry overwrites the low priority shadow.
// - fast call saves the three registers into the shadow entries.
// - fast return restores the three registers from the shadow entries.
module return_stack_fault_and_shadow
#(
   parameter int DEPTH    = `RSTACK_DEPTH,
   parameter int PC_WIDTH = `RSTACK_PC_WIDTH
)
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire rstack_pkg::seq_op_t  seq_op,
   input  wire logic [PC_WIDTH-1:0]  push_pc,
   output logic      [PC_WIDTH-1:0]  pop_pc,
   input  wire rstack_pkg::core_regs_t core_now,
   output rstack_pkg::core_regs_t    core_restore,
   output logic                      restore_valid,
   output logic                      fault_reset,
   output logic                      irq
);
   import rstack_pkg::*;

   // ***************************************************************
   // state
   // ***************************************************************
   logic [4:0]          position;
   logic [PC_WIDTH-1:0] stack_mem [1:DEPTH];
   stack_events_t       events;
   stack_events_t       event_enable;
   logic                fault_reset_enable;
   core_regs_t          shadow;
   stack_events_t       next_events;
   stack_events_t       fault_now;
   logic                fault_pending;

   // ***************************************************************
   // bus decode
   // ***************************************************************
   logic wr_access;
   logic rd_setup;
   logic mapped;

   function automatic logic is_mapped(input logic [11:0] a);
      begin
         is_mapped = (a == `RSTACK_POS_OFFSET)
                  || (a == `RSTACK_STATUS_OFFSET)
                  || (a == `RSTACK_CLEAR_OFFSET)
                  || (a == `RSTACK_ENABLE_OFFSET)
                  || (a == `RSTACK_CONFIG_OFFSET);
      end
   endfunction : is_mapped

   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      begin
         hit = wr_access && (a == o);
      end
   endfunction : hit

   // no wait states: every access completes in its first access cycle
   assign pready    = 1'b1;
   assign mapped    = is_mapped(paddr);
   assign pslverr   = psel && penable && !mapped;
   assign wr_access = psel && penable && pwrite && mapped;
   assign rd_setup  = psel && !penable && !pwrite;

   // read data is captured in the setup cycle so it stands in the access
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_setup)
      begin
         prdata <= 32'h0000_0000;
         unique case (paddr)
            `RSTACK_POS_OFFSET:
               prdata[`RSTACK_POS_MSB:`RSTACK_POS_LSB] <= position;
            `RSTACK_STATUS_OFFSET:
            begin
               prdata[`RSTACK_FULL_BIT]  <= events.full;
               prdata[`RSTACK_EMPTY_BIT] <= events.empty;
            end
            `RSTACK_ENABLE_OFFSET:
            begin
               prdata[`RSTACK_FULL_BIT]  <= event_enable.full;
               prdata[`RSTACK_EMPTY_BIT] <= event_enable.empty;
            end
            `RSTACK_CONFIG_OFFSET:
               prdata[`RSTACK_CFG_FAULT_BIT] <= fault_reset_enable;
            // clear register is write-only, unmapped reads give zero
            default:
               prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ***************************************************************
   // configuration and enables
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fault_reset_enable <= `RSTACK_CFG_RESET;
      else if (hit(paddr, `RSTACK_CONFIG_OFFSET))
         fault_reset_enable <= pwdata[`RSTACK_CFG_FAULT_BIT];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         event_enable <= `RSTACK_ENABLE_RESET;
      else if (hit(paddr, `RSTACK_ENABLE_OFFSET))
      begin
         event_enable.full  <= pwdata[`RSTACK_FULL_BIT];
         event_enable.empty <= pwdata[`RSTACK_EMPTY_BIT];
      end
   end

   // ***************************************************************
   // return stack
   // ***************************************************************
   logic push_ok;
   logic pop_ok;

   // a full stack refuses the push, an empty one returns address zero
   assign push_ok         = seq_op.push && (position < 5'(DEPTH));
   assign pop_ok          = seq_op.pop && (position != 5'h00);
   assign fault_now.full  = seq_op.push && !push_ok;
   assign fault_now.empty = seq_op.pop && !pop_ok;

   // software write wins over a core operation in the same cycle;
   // a fault reset returns the stack to empty
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         position <= `RSTACK_POS_RESET;
      else if (hit(paddr, `RSTACK_POS_OFFSET))
         position <= pwdata[`RSTACK_POS_MSB:`RSTACK_POS_LSB];
      else if (fault_reset)
         position <= `RSTACK_POS_RESET;
      else if (push_ok)
         position <= position + 5'h01;
      else if (pop_ok)
         position <= position - 5'h01;
   end

   // no reset on the array: entries are only read at the position
   always_ff @(posedge pclk)
   begin
      if (push_ok)
         stack_mem[position + 5'h01] <= push_pc;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pop_pc <= '0;
      else if (pop_ok)
         pop_pc <= stack_mem[position];
      else if (seq_op.pop)
         pop_pc <= '0;
   end

   // ***************************************************************
   // fault flags and interrupt
   // ***************************************************************
   // set wins over a software clear in the same cycle; only presetn
   // resets them, the fault reset leaves them for software to inspect
   always_comb
   begin
      next_events = events;
      if (hit(paddr, `RSTACK_CLEAR_OFFSET))
      begin
         if (pwdata[`RSTACK_FULL_BIT])
            next_events.full = 1'b0;
         if (pwdata[`RSTACK_EMPTY_BIT])
            next_events.empty = 1'b0;
      end
      if (fault_now.full)
         next_events.full = 1'b1;
      if (fault_now.empty)
         next_events.empty = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         events <= `RSTACK_EVENT_RESET;
      else
         events <= next_events;
   end

   assign irq = (events.full && event_enable.full)
             || (events.empty && event_enable.empty);

   // the flag is written on the same edge that starts the reset pulse
   assign fault_pending = fault_reset_enable
                       && (fault_now.full || fault_now.empty);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fault_reset <= 1'b0;
      else
         fault_reset <= fault_pending;
   end

   // ***************************************************************
   // fast shadow copy
   // ***************************************************************
   logic save_shadow;
   logic load_back;

   // any interrupt entry saves; a nested entry simply overwrites
   assign save_shadow = seq_op.push
                     && (seq_op.vector || seq_op.fast);
   assign load_back   = seq_op.pop && seq_op.fast;

   // kept off the bus entirely
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         shadow <= '0;
      else if (save_shadow)
         shadow <= core_now;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         core_restore <= '0;
      else if (load_back)
         core_restore <= shadow;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         restore_valid <= 1'b0;
      else
         restore_valid <= load_back;
   end

endmodule : return_stack_fault_and_shadow
`default_nettype wire

// file: test/rstack_props.sv
// assertion checker of the return stack block
`timescale 1ns/1ps
`default_nettype none
`include "rstack_regs.svh"
module rstack_props
(
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [11:0]            paddr,
   input wire logic [31:0]            prdata,
   input wire rstack_pkg::seq_op_t    seq_op,
   input wire rstack_pkg::core_regs_t core_now,
   input wire rstack_pkg::core_regs_t core_restore,
   input wire logic                   restore_valid,
   input wire logic                   fault_reset,
   input wire logic                   irq
);
   import rstack_pkg::*;
   // ********
   // checks
   // ********
   core_regs_t shadow_ref;
   logic       rd_pos;
   logic       fast_pop;
   logic       flag_wr;
   assign rd_pos = psel && penable && !pwrite && paddr == `RSTACK_POS_OFFSET;
   assign fast_pop = seq_op.pop && seq_op.fast;
   // only clear and enable writes may lower the interrupt
   assign flag_wr = psel && penable && pwrite &&
      (paddr == `RSTACK_CLEAR_OFFSET || paddr == `RSTACK_ENABLE_OFFSET);
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         shadow_ref <= '0;
      else if (seq_op.push && (seq_op.vector || seq_op.fast))
         shadow_ref <= core_now;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_pos_hi; rd_pos |-> prdata[31:5] == 27'h0; endproperty
   a_pos_hi: assert property (p_pos_hi)
      else $error("position upper bits set");
   property p_pulse; fault_reset |=> !fault_reset; endproperty
   a_pulse: assert property (p_pulse)
      else $error("fault reset too long");
   property p_cause; fault_reset |-> $past(seq_op.push || seq_op.pop); endproperty
   a_cause: assert property (p_cause)
      else $error("fault reset without push or pop");
   property p_sticky; irq && !flag_wr |=> irq; endproperty
   a_sticky: assert property (p_sticky)
      else $error("flag dropped without clear");
   property p_restore; fast_pop |=> restore_valid; endproperty
   a_restore: assert property (p_restore)
      else $error("no restore after fast pop");
   property p_only; restore_valid |-> $past(fast_pop); endproperty
   a_only: assert property (p_only)
      else $error("restore without fast pop");
   property p_hold; !fast_pop |=> $stable(core_restore); endproperty
   a_hold: assert property (p_hold)
      else $error("shadow output changed");
   property p_shadow; restore_valid |-> core_restore == shadow_ref; endproperty
   a_shadow: assert property (p_shadow)
      else $error("restored values wrong");
   cover property (fault_reset);
   cover property (restore_valid);
   cover property (irq ##1 !irq);
endmodule : rstack_props
bind return_stack_fault_and_shadow rstack_props rstack_props_i
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .seq_op(seq_op),
   .core_now(core_now), .core_restore(core_restore),
   .restore_valid(restore_valid), .fault_reset(fault_reset), .irq(irq)
);
`default_nettype wire

// file: test/rstack_seq_model.sv
// sequencer and core register stand-in at the far side
`timescale 1ns/1ps
`default_nettype none
module rstack_seq_model
(
   input  wire logic                   pclk,
   output rstack_pkg::seq_op_t         seq_op,
   output logic [20:0]                 push_pc,
   output rstack_pkg::core_regs_t      core_now,
   input  wire rstack_pkg::core_regs_t core_restore,
   input  wire logic                   restore_valid
);
   import rstack_pkg::*;
   initial {seq_op, push_pc, core_now} = '0;
   always @(posedge pclk)
      if (restore_valid === 1'b1)
         core_now <= core_restore;
   // idle edge at the end keeps the restore apart from the next op
   task automatic op(input seq_op_t o, input core_regs_t r);
      @(posedge pclk);
      seq_op <= o;
      core_now <= r;
      push_pc <= push_pc + 21'h2;
      @(posedge pclk);
      seq_op <= '0;
      push_pc <= ~push_pc;
      @(posedge pclk);
   endtask : op
endmodule : rstack_seq_model
`default_nettype wire

// file: test/tb_top.sv
// self-checking bench of the return stack block
`timescale 1ns/1ps
`default_nettype none
`include "rstack_regs.svh"
module tb_top;
   import rstack_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] q;
   logic [20:0] push_pc;
   logic [20:0] pop_pc;
   logic        pready;
   logic        pslverr;
   logic        err;
   logic        rv;
   logic        fault_reset;
   logic        irq;
   seq_op_t     seq_op;
   core_regs_t  core_now;
   core_regs_t  core_restore;
   int          fails = 0;
   int          compares = 0;
   int          resets = 0;
   always #4 pclk = ~pclk;
   always @(posedge pclk)
      if (fault_reset === 1'b1)
         resets++;
   return_stack_fault_and_shadow #(.PC_WIDTH(21))
      return_stack_fault_and_shadow_i
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .seq_op(seq_op),
      .push_pc(push_pc), .pop_pc(pop_pc), .core_now(core_now),
      .core_restore(core_restore), .restore_valid(rv),
      .fault_reset(fault_reset), .irq(irq)
   );
   rstack_seq_model seq_i
   (
      .pclk(pclk), .seq_op(seq_op), .push_pc(push_pc),
      .core_now(core_now), .core_restore(core_restore), .restore_valid(rv)
   );
   // ********
   // tasks
   // ********
   task automatic report_and_stop;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string s, input logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, logic [31:0] d);
      int n;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (n == 16)
      begin
         fails++;
         report_and_stop;
      end
      {q, err} = {prdata, pslverr};
      {psel, penable} <= 2'h0;
   endtask : apb
   task automatic rd(input string s, input logic [11:0] a, logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(s, e, q);
   endtask : rd
   task automatic chk_irq(input logic e);
      @(negedge pclk);
      chk("irq", {31'h0, e}, {31'h0, irq});
   endtask : chk_irq
   task automatic t_regs;
      rd("position", `RSTACK_POS_OFFSET, 32'h0);
      rd("status", `RSTACK_STATUS_OFFSET, 32'h0);
      rd("config", `RSTACK_CONFIG_OFFSET, 32'h1);
      apb(1'b1, `RSTACK_POS_OFFSET, 32'hFFFFFFFF);
      rd("position", `RSTACK_POS_OFFSET, 32'h1F);
      rd("unmapped", 12'h020, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      $display("test regs done");
   endtask : t_regs
   task automatic t_shadow;
      apb(1'b1, `RSTACK_POS_OFFSET, 32'h0);
      seq_i.op(4'hA, 24'h112233);
      seq_i.op(4'hA, 24'h445566);
      seq_i.op(4'h5, 24'h778899);
      @(negedge pclk);
      chk("restore", 32'h445566, {8'h0, core_now});
      chk("pop_pc", 32'h001FFFFF, {11'h0, pop_pc});
      rd("position", `RSTACK_POS_OFFSET, 32'h1);
      // a fast call saves its own copy and the fast return puts it back
      seq_i.op(4'h4, 24'h112233);
      seq_i.op(4'h9, 24'hA1B2C3);
      seq_i.op(4'h5, 24'h0F0F0F);
      @(negedge pclk);
      chk("restore", 32'hA1B2C3, {8'h0, core_now});
      $display("test shadow done");
   endtask : t_shadow
   task automatic t_fault;
      apb(1'b1, `RSTACK_ENABLE_OFFSET, 32'h3);
      apb(1'b1, `RSTACK_POS_OFFSET, 32'h1F);
      seq_i.op(4'h8, core_now);
      rd("status", `RSTACK_STATUS_OFFSET, 32'h1);
      chk("resets", 32'h1, resets);
      rd("position", `RSTACK_POS_OFFSET, 32'h0);
      apb(1'b1, `RSTACK_CONFIG_OFFSET, 32'h0);
      seq_i.op(4'h4, core_now);
      rd("status", `RSTACK_STATUS_OFFSET, 32'h3);
      chk("resets", 32'h1, resets);
      apb(1'b1, `RSTACK_ENABLE_OFFSET, 32'h2);
      chk_irq(1'b1);
      apb(1'b1, `RSTACK_CLEAR_OFFSET, 32'h2);
      chk_irq(1'b0);
      rd("status", `RSTACK_STATUS_OFFSET, 32'h1);
      apb(1'b1, `RSTACK_CLEAR_OFFSET, 32'h1);
      rd("status", `RSTACK_STATUS_OFFSET, 32'h0);
      $display("test fault done");
   endtask : t_fault
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_shadow;
      t_fault;
      report_and_stop;
   end
endmodule : tb_top
`default_nettype wire
